/* File: bench/bidir_reset_config_latch_properties.sv */
`timescale 1ns/10ps
module bidir_reset_config_latch_properties #(
	parameter int SEQ_CYCLES = 512
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic RESET_IN_N_I,
	input wire logic RESET_IN_N_OE,
	input wire logic RESET_OUT_N,
	input wire logic RC_ABOVE_THRESHOLD,
	input wire logic RC_PULLDOWN_EN,
	input wire logic RC_PULLUP_EN,
	input wire logic END_OF_INIT_INSTR,
	input wire logic CPU_RESET,
	input wire logic CONFIG_LATCHED
);
	logic [15:0] held_cnt;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);
	// Cycles the CPU has been held in reset
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || !CPU_RESET) begin
			held_cnt <= 16'h0000;
		end else begin
			held_cnt <= held_cnt + 16'h0001;
		end
	end
	start_low_a:
		assert property ($rose(CPU_RESET) |-> !RESET_OUT_N)
		else $error("reset output high at sequence start");
	held_low_a:
		assert property (CPU_RESET |-> !RESET_OUT_N)
		else $error("reset output high while CPU in reset");
	init_end_a:
		assert property ($rose(RESET_OUT_N) |->
			$past(END_OF_INIT_INSTR) || $past(END_OF_INIT_INSTR, 2))
		else $error("reset output released without end of init");
	stay_high_a:
		assert property ($fell(RESET_OUT_N) |-> $rose(CPU_RESET))
		else $error("reset output fell outside a sequence start");
	fetch_free_a:
		assert property (RESET_IN_N_OE |-> CPU_RESET)
		else $error("reset input pulled after CPU release");
	pull_span_a:
		assert property ($fell(RESET_IN_N_OE) |-> held_cnt <= SEQ_CYCLES + 2)
		else $error("reset input pulled past sequence end");
	seq_len_a:
		assert property ($fell(CPU_RESET) |-> held_cnt >= SEQ_CYCLES + 3)
		else $error("reset sequence too short");
	rc_cancel_a:
		assert property (!RC_ABOVE_THRESHOLD [*5] |-> !RESET_IN_N_OE)
		else $error("pull kept with RC level low");
	rc_drain_a:
		assert property (!RESET_IN_N_I [*4] |-> RC_PULLDOWN_EN)
		else $error("RC pull-down off while reset input low");
	pullup_run_a:
		assert property (RC_PULLUP_EN |-> !CPU_RESET)
		else $error("RC pull-up on inside sequence");
	latch_wait_a:
		assert property ($rose(RESET_IN_N_I) && CPU_RESET |-> CPU_RESET [*3])
		else $error("configuration latched too early");
	latch_pulse_a:
		assert property (CONFIG_LATCHED == $fell(CPU_RESET))
		else $error("configuration latch pulse misplaced");
	cover property ($rose(RESET_IN_N_OE));
	cover property (CONFIG_LATCHED);
	cover property (!RC_ABOVE_THRESHOLD && RESET_IN_N_OE);
endmodule : bidir_reset_config_latch_properties

bind bidir_reset_config_latch bidir_reset_config_latch_properties #(
	.SEQ_CYCLES(SEQ_CYCLES)
) bidir_reset_config_latch_properties_i (
	.CLOCK, .SYS_RST, .RESET_IN_N_I, .RESET_IN_N_OE, .RESET_OUT_N,
	.RC_ABOVE_THRESHOLD, .RC_PULLDOWN_EN, .RC_PULLUP_EN,
	.END_OF_INIT_INSTR, .CPU_RESET, .CONFIG_LATCHED
);

/* File: bench/bidir_reset_config_latch_test.sv */
`timescale 1ns/10ps
module bidir_reset_config_latch_test;
	import reset_seq_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rc = 1'b1;
	logic eoi = 1'b0;
	logic swr = 1'b0;
	logic wdo = 1'b0;
	logic byp = 1'b0;
	logic hold = 1'b0;
	logic ea = 1'b1;
	port_cfg_t cfg = 16'hA5FF;
	reg_req_t req = '0;
	logic pin_n, oe, pin_o, out_n, pd, pu, cpu_rst, latched;
	logic [15:0] rdata;
	int n_mismatch = 0;
	int compares = 0;
	always #10 clk = ~clk;
	bidir_reset_config_latch #(.SEQ_CYCLES(16)) bidir_reset_config_latch_i (
		.CLOCK(clk), .SYS_RST(rst), .RESET_IN_N_I(pin_n),
		.RESET_IN_N_O(pin_o), .RESET_IN_N_OE(oe), .RESET_OUT_N(out_n),
		.RC_ABOVE_THRESHOLD(rc), .RC_PULLDOWN_EN(pd), .RC_PULLUP_EN(pu),
		.CONFIG_PORT(cfg), .EXTERNAL_ACCESS_N(ea), .PLL_BYPASS(byp),
		.END_OF_INIT_INSTR(eoi), .SOFTWARE_RESET_INSTR(swr),
		.WATCHDOG_OVERFLOW(wdo), .CPU_RESET(cpu_rst),
		.CONFIG_LATCHED(latched), .REG_REQ(req), .REG_RDATA(rdata));
	ext_reset_line ext_reset_line_i (.clk(clk), .req_low(hold), .dev_oe(oe),
		.dev_o(pin_o), .pin_n(pin_n));
	task automatic results();
		$display("Mismatches %0d Compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		req <= '0;
		#1 chk(rdata, e);
	endtask : rd
	task automatic wait_for(input logic v);
		int i;
		for (i = 0; i < 300 && cpu_rst !== v; i++) begin
			@(posedge clk);
		end
		if (i == 300) begin
			n_mismatch++;
			results();
		end
	endtask : wait_for
	// Pulse 0 end of init, 1 software reset, 2 watchdog
	task automatic fire(input int k);
		@(posedge clk);
		eoi <= (k == 0);
		swr <= (k == 1);
		wdo <= (k == 2);
		@(posedge clk);
		{eoi, swr, wdo} <= 3'h0;
		@(posedge clk);
		#1;
	endtask : fire
	task automatic hw(input int n);
		@(posedge clk);
		hold <= 1'b1;
		repeat (n) @(posedge clk);
		#1 chk(pd, 1'b1);
		@(posedge clk);
		hold <= 1'b0;
		wait_for(1'b1);
	endtask : hw
	task automatic regs(input logic [15:0] sh, bus, st);
		wait_for(1'b0);
		repeat (2) @(posedge clk);
		rd(8'h04, sh);
		rd(8'h08, bus);
		rd(8'h0C, st);
	endtask : regs
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		regs(16'h00A5, 16'h06C0, 16'h0000);
		chk(out_n, 1'b0);
		wr(8'h00, 16'h0020);
		fire(0);
		chk(out_n, 1'b1);
		wr(8'h00, 16'h0028);
		rd(8'h00, 16'h0020);
		chk(pu, 1'b1);
		@(posedge clk) cfg <= 16'hFFFF;
		fire(1);
		chk(out_n, 1'b0);
		chk(pu, 1'b0);
		regs(16'h00BF, 16'h06C0, 16'h0004);
		rd(8'h10, 16'hBFC3);
		chk(pu, 1'b1);
		@(posedge clk) cfg <= 16'h0000;
		fire(2);
		chk(out_n, 1'b0);
		regs(16'h00A0, 16'h0600, 16'h0005);
		wr(8'h00, 16'h0028);
		rd(8'h00, 16'h0028);
		@(posedge clk) cfg <= 16'h5A3C;
		fire(1);
		chk(oe, 1'b1);
		rd(8'h0C, 16'h0033);
		rd(8'h00, 16'h0020);
		regs(16'h00BA, 16'h0600, 16'h0003);
		@(posedge clk) cfg <= 16'h1234;
		hw(6);
		regs(16'h00B2, 16'h0600, 16'h0003);
		@(posedge clk);
		cfg <= 16'hFFFF;
		byp <= 1'b1;
		hw(40);
		regs(16'h00FF, 16'h06C0, 16'h0002);
		@(posedge clk);
		cfg <= 16'h0000;
		rc <= 1'b0;
		ea <= 1'b0;
		hw(6);
		regs(16'h0000, 16'h0000, 16'h0001);
		@(posedge clk);
		rc <= 1'b1;
		byp <= 1'b0;
		ea <= 1'b1;
		wr(8'h00, 16'h0028);
		fire(1);
		@(posedge clk) rc <= 1'b0;
		repeat (6) @(posedge clk);
		#1 chk(oe, 1'b0);
		@(posedge clk) rc <= 1'b1;
		regs(16'h0000, 16'h0600, 16'h0001);
		results();
	end
endmodule : bidir_reset_config_latch_test

/* File: bench/ext_reset_line.sv */
`timescale 1ns/10ps
module ext_reset_line (
	input wire logic clk,
	input wire logic req_low,
	input wire logic dev_oe,
	input wire logic dev_o,
	output logic pin_n
);
	logic [1:0] stretch_reg = 2'h0;
	// A low request lasts two clocks at least
	always_ff @(posedge clk) begin
		if (req_low) begin
			stretch_reg <= 2'h2;
		end else if (stretch_reg != 2'h0) begin
			stretch_reg <= stretch_reg - 2'h1;
		end
	end
	// Pull-up wins unless a party pulls the line down
	assign pin_n = !(req_low || stretch_reg != 2'h0 || (dev_oe && !dev_o));
endmodule : ext_reset_line

/* File: rtl/bidir_reset_config_latch.sv */
`timescale 1ns/10ps
`include "reset_seq_cfg.svh"
// Behaviour
// - Reset output low at every sequence start
// - Reset output held low until end-of-init
// - Bit 3 enables bidirectional reset
// - Every reset sequence clears bidirectional enable
// - Enable accepted only before end-of-init
// - Low RC level cancels pull, forces async except after POR
// - Pull reset input low during whole sequence
// - Internal sequence lasts 512 CPU clocks
// - Pull released before first instruction fetch
// - Bidir soft/watchdog resets act as hardware
// - RC weak pull-down while reset input low
// - RC pull-up after sequence if powerdown set
// - New reset async if RC low, else sync
// - Sampled port bits depend on reset kind
// - Latched fields copied to shadow and bus
// - Latch config 4 clocks after rise, 3 bypassed
// - Soft/watchdog resets clear bits 5 to 2
module bidir_reset_config_latch
	import reset_seq_pkg::*;
#(
	parameter int SEQ_CYCLES = `SEQ_CPU_CYCLES,
	parameter int DETECT = `DETECT_CYCLES
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic RESET_IN_N_I,
	output logic RESET_IN_N_O,
	output logic RESET_IN_N_OE,
	output logic RESET_OUT_N,
	input wire logic RC_ABOVE_THRESHOLD,
	output logic RC_PULLDOWN_EN,
	output logic RC_PULLUP_EN,
	input wire port_cfg_t CONFIG_PORT,
	input wire logic EXTERNAL_ACCESS_N,
	input wire logic PLL_BYPASS,
	input wire logic END_OF_INIT_INSTR,
	input wire logic SOFTWARE_RESET_INSTR,
	input wire logic WATCHDOG_OVERFLOW,
	output logic CPU_RESET,
	output logic CONFIG_LATCHED,
	input wire reg_req_t REG_REQ,
	output logic [15:0] REG_RDATA
);

	typedef enum logic [2:0] {
		ST_SEQ,
		ST_EXTEND,
		ST_LATCH_WAIT,
		ST_INIT,
		ST_RUN
	} state_t;

	localparam int SEQ_W = $clog2(SEQ_CYCLES + 1);

	state_t state_reg;
	reset_kind_t kind_reg;
	logic [SEQ_W-1:0] seq_cnt_reg;
	logic [2:0] latch_cnt_reg;
	logic [1:0] low_cnt_reg;
	logic pull_active_reg;
	logic pull_used_reg;
	logic bidir_reset_enable;
	logic powerdown_config_bit;
	logic init_done_reg;
	logic reset_out_n_reg;
	logic cpu_reset_reg;
	logic latch_strobe_reg;
	logic [15:0] rdata_reg;

	logic [18:0] pin_sync;
	port_cfg_t port_sync;
	logic rst_in_low;
	logic rc_above;
	logic ext_access_n_sync;
	logic running;
	logic hw_start;
	logic soft_start;
	logic seq_start;
	logic seq_last;
	logic latch_last;
	logic [2:0] latch_delay;
	logic rc_cancel;
	logic [15:0] shadow;
	logic [15:0] bus_cfg;
	logic [15:0] status;
	port_cfg_t latched_cfg;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	sync_two_ff #(
		.WIDTH(19),
		.RESET_VAL(19'h7FFFF)
	) u_pin_sync (
		.clk(CLOCK),
		.rst(SYS_RST),
		.d({RESET_IN_N_I, RC_ABOVE_THRESHOLD, EXTERNAL_ACCESS_N,
			CONFIG_PORT}),
		.q(pin_sync)
	);

	assign rst_in_low = ~pin_sync[18];
	assign rc_above = pin_sync[17];
	assign ext_access_n_sync = pin_sync[16];
	assign port_sync = port_cfg_t'(pin_sync[15:0]);

	////////////////////////////////////////////////////////////////////////
	// Sequence control

	assign running = (state_reg == ST_INIT) || (state_reg == ST_RUN);
	assign hw_start = running && rst_in_low
		&& (low_cnt_reg == 2'(DETECT - 1));
	assign soft_start = running && !hw_start
		&& (SOFTWARE_RESET_INSTR || WATCHDOG_OVERFLOW);
	assign seq_start = hw_start || soft_start;
	assign seq_last = (seq_cnt_reg == SEQ_W'(SEQ_CYCLES - 1));
	assign latch_delay = PLL_BYPASS ? 3'(`LATCH_DELAY_BYPASS)
		: 3'(`LATCH_DELAY_PLL);
	assign latch_last = (latch_cnt_reg == latch_delay - 3'h1);
	assign rc_cancel = ((state_reg == ST_SEQ) || (state_reg == ST_EXTEND))
		&& !rc_above && (rst_in_low || pull_active_reg);

	// Consecutive low samples of the reset input
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || !rst_in_low) begin
			low_cnt_reg <= 2'h0;
		end else if (low_cnt_reg != 2'h3) begin
			low_cnt_reg <= low_cnt_reg + 2'h1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			state_reg <= ST_SEQ;
		end else begin
			case (state_reg)
				ST_SEQ: if (seq_last) state_reg <= ST_EXTEND;
				ST_EXTEND: if (!rst_in_low) state_reg <= ST_LATCH_WAIT;
				ST_LATCH_WAIT: if (latch_last) state_reg <= ST_INIT;
				ST_INIT: begin
					if (seq_start) begin
						state_reg <= ST_SEQ;
					end else if (END_OF_INIT_INSTR) begin
						state_reg <= ST_RUN;
					end
				end
				ST_RUN: if (seq_start) state_reg <= ST_SEQ;
				default: state_reg <= ST_SEQ;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST || seq_start || state_reg != ST_SEQ) begin
			seq_cnt_reg <= '0;
		end else begin
			seq_cnt_reg <= seq_cnt_reg + SEQ_W'(1);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST || state_reg != ST_LATCH_WAIT) begin
			latch_cnt_reg <= 3'h0;
		end else begin
			latch_cnt_reg <= latch_cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			kind_reg <= KIND_POR;
		end else if (hw_start) begin
			kind_reg <= rc_above ? KIND_SHORT_HW : KIND_ASYNC;
		end else if (soft_start && bidir_reset_enable) begin
			kind_reg <= KIND_SHORT_HW;
		end else if (soft_start) begin
			kind_reg <= SOFTWARE_RESET_INSTR ? KIND_SOFTWARE : KIND_WATCHDOG;
		end else if (rc_cancel && kind_reg != KIND_POR) begin
			kind_reg <= KIND_ASYNC;
		end else if (state_reg == ST_SEQ && seq_last && rst_in_low
			&& !pull_used_reg && kind_reg == KIND_SHORT_HW) begin
			kind_reg <= KIND_LONG_HW;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bidirectional pull-down on the reset input

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			pull_active_reg <= 1'b0;
		end else if (seq_start) begin
			pull_active_reg <= bidir_reset_enable;
		end else if (rc_cancel || (state_reg == ST_SEQ && seq_last)) begin
			pull_active_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			pull_used_reg <= 1'b0;
		end else if (seq_start) begin
			pull_used_reg <= bidir_reset_enable;
		end
	end

	assign RESET_IN_N_O = 1'b0;
	assign RESET_IN_N_OE = pull_active_reg;
	assign RC_PULLDOWN_EN = rst_in_low || pull_active_reg;
	assign RC_PULLUP_EN = powerdown_config_bit && running;

	////////////////////////////////////////////////////////////////////////
	// Reset output, CPU reset and init tracking

	always_ff @(posedge CLOCK) begin
		if (SYS_RST || seq_start) begin
			reset_out_n_reg <= 1'b0;
		end else if (state_reg == ST_INIT && END_OF_INIT_INSTR) begin
			reset_out_n_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST || seq_start) begin
			init_done_reg <= 1'b0;
		end else if (state_reg == ST_INIT && END_OF_INIT_INSTR) begin
			init_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST || seq_start) begin
			cpu_reset_reg <= 1'b1;
		end else if (state_reg == ST_LATCH_WAIT && latch_last) begin
			cpu_reset_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			latch_strobe_reg <= 1'b0;
		end else begin
			latch_strobe_reg <= (state_reg == ST_LATCH_WAIT) && latch_last;
		end
	end

	assign RESET_OUT_N = reset_out_n_reg;
	assign CPU_RESET = cpu_reset_reg;
	assign CONFIG_LATCHED = latch_strobe_reg;

	////////////////////////////////////////////////////////////////////////
	// Configuration latching

	config_latch u_config_latch (
		.clk(CLOCK),
		.rst(SYS_RST),
		.strobe(latch_strobe_reg),
		.kind(kind_reg),
		.port(port_sync),
		.ext_access_n(ext_access_n_sync),
		.latched(latched_cfg),
		.shadow(shadow),
		.bus_cfg(bus_cfg)
	);

	////////////////////////////////////////////////////////////////////////
	// Register port

	always_ff @(posedge CLOCK) begin
		if (SYS_RST || seq_start) begin
			bidir_reset_enable <= 1'b0;
		end else if (REG_REQ.wr && REG_REQ.addr == `OFS_SYSTEM_CONFIG) begin
			if (!REG_REQ.wdata[`SYSCFG_BIDIR_BIT]) begin
				bidir_reset_enable <= 1'b0;
			end else if (!init_done_reg) begin
				bidir_reset_enable <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			powerdown_config_bit <= 1'b0;
		end else if (REG_REQ.wr && REG_REQ.addr == `OFS_SYSTEM_CONFIG) begin
			powerdown_config_bit <= REG_REQ.wdata[`SYSCFG_PWD_BIT];
		end
	end

	always_comb begin
		status = `REG_RESET_VAL;
		status[`STAT_KIND_LSB +: 3] = kind_reg;
		status[`STAT_INIT_DONE_BIT] = init_done_reg;
		status[`STAT_IN_RESET_BIT] = cpu_reset_reg;
		status[`STAT_PULL_BIT] = pull_active_reg;
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST || !REG_REQ.rd) begin
			rdata_reg <= `REG_RESET_VAL;
		end else begin
			case (REG_REQ.addr)
				`OFS_SYSTEM_CONFIG: begin
					rdata_reg <= `REG_RESET_VAL;
					rdata_reg[`SYSCFG_BIDIR_BIT] <= bidir_reset_enable;
					rdata_reg[`SYSCFG_PWD_BIT] <= powerdown_config_bit;
				end
				`OFS_PORT_SHADOW: rdata_reg <= shadow;
				`OFS_BUS_CONFIG_ZERO: rdata_reg <= bus_cfg;
				`OFS_RESET_STATUS: rdata_reg <= status;
				`OFS_PORT_LATCH: rdata_reg <= latched_cfg;
				default: rdata_reg <= `REG_RESET_VAL;
			endcase
		end
	end

	assign REG_RDATA = rdata_reg;

endmodule : bidir_reset_config_latch

/* File: rtl/config_latch.sv */
`timescale 1ns/10ps
`include "reset_seq_cfg.svh"
module config_latch
	import reset_seq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic strobe,
	input wire reset_kind_t kind,
	input wire port_cfg_t port,
	input wire logic ext_access_n,
	output port_cfg_t latched,
	output logic [15:0] shadow,
	output logic [15:0] bus_cfg
);

	logic [15:0] sample_mask;
	logic [15:0] clear_mask;
	port_cfg_t latched_next;

	always_comb begin
		sample_mask = `MASK_ALL;
		clear_mask = `REG_RESET_VAL;
		case (kind)
			KIND_SOFTWARE, KIND_WATCHDOG: begin
				sample_mask = `MASK_SOFT;
				clear_mask = `CLEAR_SOFT;
			end
			KIND_SHORT_HW: sample_mask = `MASK_SHORT;
			default: sample_mask = `MASK_ALL;
		endcase
		latched_next = port_cfg_t'(((port & sample_mask)
			| (latched & ~sample_mask)) & ~clear_mask);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			latched <= port_cfg_t'(`REG_RESET_VAL);
		end else if (strobe) begin
			latched <= latched_next;
		end
	end

	// High byte fields land in the low byte of the shadow
	always_ff @(posedge clk) begin
		if (rst) begin
			shadow <= `REG_RESET_VAL;
		end else if (strobe) begin
			shadow <= {8'h00, latched_next[15:8]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_cfg <= `REG_RESET_VAL;
		end else if (strobe) begin
			bus_cfg <= `REG_RESET_VAL;
			bus_cfg[`BUSCFG_TYPE_LSB +: 2] <= latched_next.bus_type_field;
			bus_cfg[`BUSCFG_ALE_BIT] <= ext_access_n;
			bus_cfg[`BUSCFG_ACT_BIT] <= ext_access_n;
		end
	end

endmodule : config_latch

/* File: rtl/sync_two_ff.sv */
`timescale 1ns/10ps
module sync_two_ff #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule : sync_two_ff

/* File: shared/reset_seq_cfg.svh */
`ifndef RESET_SEQ_CFG_SVH
`define RESET_SEQ_CFG_SVH

// Timing counts in CPU clock cycles
`define SEQ_CPU_CYCLES 512
`define DETECT_CYCLES 2
`define LATCH_DELAY_PLL 4
`define LATCH_DELAY_BYPASS 3

// Register byte offsets
`define OFS_SYSTEM_CONFIG 8'h00
`define OFS_PORT_SHADOW 8'h04
`define OFS_BUS_CONFIG_ZERO 8'h08
`define OFS_RESET_STATUS 8'h0C
`define OFS_PORT_LATCH 8'h10

// System configuration fields
`define SYSCFG_BIDIR_BIT 3
`define SYSCFG_PWD_BIT 5

// Bus configuration fields
`define BUSCFG_TYPE_LSB 6
`define BUSCFG_ALE_BIT 9
`define BUSCFG_ACT_BIT 10

// Status fields
`define STAT_KIND_LSB 0
`define STAT_INIT_DONE_BIT 3
`define STAT_IN_RESET_BIT 4
`define STAT_PULL_BIT 5

// Port sampling masks per reset kind
`define MASK_SOFT 16'h1FC0
`define CLEAR_SOFT 16'h003C
`define MASK_SHORT 16'h1FFF
`define MASK_ALL 16'hFFFF

`define REG_RESET_VAL 16'h0000

`endif

/* File: shared/reset_seq_pkg.sv */
package reset_seq_pkg;

	typedef enum logic [2:0] {
		KIND_POR,
		KIND_ASYNC,
		KIND_LONG_HW,
		KIND_SHORT_HW,
		KIND_SOFTWARE,
		KIND_WATCHDOG
	} reset_kind_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	// Configuration port layout, bit 15 down to bit 0
	typedef struct packed {
		logic [2:0] clock_config_field;
		logic [1:0] segment_addr_select;
		logic [1:0] chip_select_count;
		logic write_config_bit;
		logic [1:0] bus_type_field;
		logic reserved_5;
		logic bootstrap_select;
		logic [1:0] reserved_3_2;
		logic adapt_mode;
		logic emu_mode;
	} port_cfg_t;

endpackage : reset_seq_pkg
